// ==== logic/mtu_map.svh ====
// register offsets, field positions, reset values and timing counts of the trigger unit
`ifndef MTU_MAP_SVH
`define MTU_MAP_SVH
`define MTU_OFF_CTRL     12'h000
`define MTU_OFF_THRESH   12'h004
`define MTU_OFF_DELAY    12'h008
`define MTU_OFF_TIMEOUT  12'h00c
`define MTU_OFF_GAP      12'h010
`define MTU_OFF_STATUS   12'h014
`define MTU_OFF_IRQ_STAT 12'h018
`define MTU_OFF_IRQ_MASK 12'h01c
`define MTU_OFF_STAMP    12'h020
`define MTU_CTRL_SRC_LSB 0
`define MTU_CTRL_SRC_W   3
`define MTU_CTRL_SLOPE   3
`define MTU_CTRL_REMOTE  4
`define MTU_CTRL_ARM     5
`define MTU_CTRL_MARK_LSB 8
`define MTU_CTRL_MARK_W  2
`define MTU_IRQ_START    0
`define MTU_IRQ_TRIG     1
`define MTU_IRQ_TOUT     2
`define MTU_RST_THRESH   16'h8000
`define MTU_RST_TIMEOUT  32'h05f5e100
`define MTU_RST_GAP      16'h0064
`define MTU_RST_DELAY    32'h00000000
`endif

// ==== logic/mtu_pkg.sv ====
// types shared by the trigger unit files
package mtu_pkg;
    typedef enum logic [2:0] {
        MTU_SRC_FREE  = 3'h0,
        MTU_SRC_POWER = 3'h1,
        MTU_SRC_EXT_A = 3'h2,
        MTU_SRC_EXT_B = 3'h3,
        MTU_SRC_MARK  = 3'h4,
        MTU_SRC_SIG   = 3'h5
    } mtu_src_e;
    typedef enum logic [3:0] {
        MTU_ST_IDLE  = 4'b0001,
        MTU_ST_WAIT  = 4'b0010,
        MTU_ST_DELAY = 4'b0100,
        MTU_ST_RUN   = 4'b1000
    } mtu_state_e;
endpackage

// ==== logic/mtu_qual_if.sv ====
// carrier between the trigger qualifier and the sequencer
`timescale 1ns/1ps
interface mtu_qual_if;
    logic        edge_sel;   // 1 = falling edge
    logic [15:0] thresh;     // power threshold
    logic [15:0] gap_len;    // minimum gap in cycles
    logic        enable;     // power source selected
    logic        event_p;    // qualified power event
    modport qual (input edge_sel, thresh, gap_len, enable, output event_p);
    modport seq  (output edge_sel, thresh, gap_len, enable, input event_p);
endinterface

// ==== logic/mtu_power_qual.sv ====
// power level crossing detector with slope and minimum gap qualification
`timescale 1ns/1ps
module mtu_power_qual (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] level,
    mtu_qual_if.qual         q
);
    import mtu_pkg::*;
    typedef struct packed {
        logic        above;   // level at or over threshold last cycle
        logic [15:0] gap_cnt; // cycles spent below threshold
        logic        gap_ok;  // gap long enough
        logic        ev;      // event pulse
    } mtu_pq_s;
    mtu_pq_s s_q, s_d;
    // ************************************************
    // crossing detection
    // ************************************************
    always_comb begin
        logic now_above;
        logic rise;
        logic fall;
        now_above = (level >= q.thresh);
        s_d       = s_q;
        rise      = !s_q.above && now_above;
        fall      = s_q.above && !now_above;
        s_d.above = now_above;
        s_d.ev    = 1'b0;
        // gap time only accrues below threshold, so sub-threshold wiggles never fire
        if (!now_above) begin
            if (s_q.gap_cnt != 16'hffff) begin
                s_d.gap_cnt = s_q.gap_cnt + 16'h0001;
            end
        end else begin
            s_d.gap_cnt = 16'h0000;
        end
        if (s_q.gap_cnt >= q.gap_len) begin
            s_d.gap_ok = 1'b1;
        end
        if (q.enable && s_q.gap_ok) begin
            if ((!q.edge_sel && rise) || (q.edge_sel && fall)) begin
                s_d.ev     = 1'b1;
                s_d.gap_ok = 1'b0;
            end
        end
    end
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign q.event_p = s_q.ev;
endmodule

// ==== logic/mtu_top.sv ====
// measurement trigger unit: source select, delay, timeout and apb registers
// Notes on behaviour
// - free run starts acquisitions back to back
// - power source fires on threshold crossing
// - slope picks rising or falling edge of the power crossing; other sources take rising edges only
// - levels below threshold raise no event
// - either external input selectable as source
// - generator markers 0 to 3 are selectable (two-bit index)
// - signaling events aligned to downlink
// - start delayed by programmed trigger delay
// - no trigger within timeout flags timeout
// - remote mode timeout also stops measurement
// - power trigger needs minimum preceding gap
// - qualifiers ignored in free run
// - trigger instant is timing reference
`timescale 1ns/1ps
`include "mtu_map.svh"
module mtu_top #(
    parameter int MARK_N = 4
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [15:0]       power_level,
    input  wire logic              ext_trigger_in_first,
    input  wire logic              ext_trigger_in_second,
    input  wire logic [MARK_N-1:0] marker_in,
    input  wire logic              downlink_frame,
    output logic                   meas_start,
    output logic                   meas_busy,
    output logic                   trig_timeout,
    output logic                   irq
);
    import mtu_pkg::*;
    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic [2:0]        ext_a;    // sync chain, first ext input
        logic [2:0]        ext_b;    // sync chain, second ext input
        logic [2:0]        sig;      // sync chain, downlink frame
        logic [MARK_N-1:0] mk1;      // marker sync stage 1
        logic [MARK_N-1:0] mk2;      // marker sync stage 2
        logic [MARK_N-1:0] mk3;      // marker edge history
        logic [2:0]        src;      // selected source
        logic              slope;    // 1 = falling
        logic              remote;   // remote control mode
        logic              arm;      // measurement armed
        logic [1:0]        mark_sel; // marker index
        logic [15:0]       thresh;
        logic [31:0]       delay;
        logic [31:0]       tout;
        logic [15:0]       gap;
        mtu_state_e        st;
        logic [31:0]       dcnt;     // delay counter
        logic [31:0]       tcnt;     // timeout counter
        logic [31:0]       clk_cnt;  // free running time base
        logic [31:0]       stamp;    // last trigger instant
        logic [2:0]        irq_st;
        logic [2:0]        irq_mk;
        logic              timed_out;
        logic              start;
        logic [31:0]       rdata;
        logic              rdy;
        logic              err;
        logic              irq;
        logic              busy;     // sequencer away from idle, registered for the pin
    } mtu_s;
    mtu_s s_q, s_d;
    mtu_qual_if qif ();
    // power crossing qualifier
    mtu_power_qual u_pq (
        .pclk    (pclk),
        .presetn (presetn),
        .level   (power_level),
        .q       (qif.qual)
    );
    assign qif.edge_sel = s_q.slope;
    assign qif.thresh   = s_q.thresh;
    assign qif.gap_len  = s_q.gap;
    assign qif.enable   = (s_q.src == MTU_SRC_POWER);
    // ************************************************
    // helpers
    // ************************************************
    // rising edge of a synchronised level (stage 2 vs 3)
    function automatic logic mtu_rise(input logic [2:0] c);
        return c[1] && !c[2];
    endfunction
    // decode an apb address match
    function automatic logic mtu_hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction
    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        logic       trig;
        logic       wr;
        logic       rd;
        logic [2:0] ev;
        logic       mk_now;
        logic       mk_old;
        s_d   = s_q;
        ev    = 3'h0;
        trig   = 1'b0;
        wr     = 1'b0;
        rd     = 1'b0;
        mk_now = 1'b0;
        mk_old = 1'b0;
        // ext, marker and downlink pins pass two flops before any edge logic reads them; the power level reaches the qualifier compare unsynchronised
        s_d.ext_a = {s_q.ext_a[1:0], ext_trigger_in_first};
        s_d.ext_b = {s_q.ext_b[1:0], ext_trigger_in_second};
        s_d.sig   = {s_q.sig[1:0], downlink_frame};
        s_d.mk1   = marker_in;
        s_d.mk2   = s_q.mk1;
        s_d.mk3   = s_q.mk2;
        s_d.clk_cnt = s_q.clk_cnt + 32'h00000001;
        mk_now = s_q.mk2[s_q.mark_sel];
        mk_old = s_q.mk3[s_q.mark_sel];
        // source multiplexer
        case (s_q.src)
            MTU_SRC_POWER: trig = qif.event_p;
            MTU_SRC_EXT_A: trig = mtu_rise(s_q.ext_a);
            MTU_SRC_EXT_B: trig = mtu_rise(s_q.ext_b);
            MTU_SRC_MARK:  trig = mk_now && !mk_old;
            MTU_SRC_SIG:   trig = mtu_rise(s_q.sig);
            default:       trig = 1'b0;
        endcase
        s_d.start = 1'b0;
        // sequencer
        case (s_q.st)
            MTU_ST_IDLE: begin
                if (s_q.arm) begin
                    s_d.tcnt      = 32'h00000000;
                    s_d.timed_out = 1'b0;
                    s_d.st        = MTU_ST_WAIT;
                end
            end
            MTU_ST_WAIT: begin
                if (!s_q.arm) begin
                    s_d.st = MTU_ST_IDLE;
                end else if (s_q.src == MTU_SRC_FREE || trig) begin
                    s_d.tcnt  = 32'h00000000;
                    s_d.stamp = s_q.clk_cnt;
                    s_d.dcnt  = s_q.delay;
                    s_d.st    = MTU_ST_DELAY;
                    if (s_q.src != MTU_SRC_FREE) begin
                        ev[`MTU_IRQ_TRIG] = 1'b1;
                    end
                end else if (s_q.tout != 32'h00000000 &&
                             s_q.tcnt >= s_q.tout - 32'h00000001) begin
                    s_d.timed_out     = 1'b1;
                    ev[`MTU_IRQ_TOUT] = 1'b1;
                    s_d.tcnt          = 32'h00000000;
                    if (s_q.remote) begin
                        s_d.arm = 1'b0;
                        s_d.st  = MTU_ST_IDLE;
                    end
                end else begin
                    s_d.tcnt = s_q.tcnt + 32'h00000001;
                end
            end
            MTU_ST_DELAY: begin
                if (s_q.dcnt == 32'h00000000) begin
                    s_d.start          = 1'b1;
                    ev[`MTU_IRQ_START] = 1'b1;
                    s_d.st             = MTU_ST_RUN;
                end else begin
                    s_d.dcnt = s_q.dcnt - 32'h00000001;
                end
            end
            MTU_ST_RUN: begin
                // back to waiting at once: free run restarts at the fastest rate
                s_d.st = s_q.arm ? MTU_ST_WAIT : MTU_ST_IDLE;
            end
            default: s_d.st = MTU_ST_IDLE;
        endcase
        // ************************************************
        // apb slave, access phase with one wait state
        // ************************************************
        wr      = psel && penable && pwrite && !s_q.rdy;
        rd      = psel && penable && !pwrite && !s_q.rdy;
        s_d.rdy = psel && penable && !s_q.rdy;
        s_d.err = 1'b0;
        if (wr) begin
            if (mtu_hit(paddr, `MTU_OFF_CTRL)) begin
                s_d.src      = pwdata[`MTU_CTRL_SRC_LSB +: `MTU_CTRL_SRC_W];
                s_d.slope    = pwdata[`MTU_CTRL_SLOPE];
                s_d.remote   = pwdata[`MTU_CTRL_REMOTE];
                s_d.arm      = pwdata[`MTU_CTRL_ARM];
                s_d.mark_sel = pwdata[`MTU_CTRL_MARK_LSB +: `MTU_CTRL_MARK_W];
            end else if (mtu_hit(paddr, `MTU_OFF_THRESH)) begin
                s_d.thresh = pwdata[15:0];
            end else if (mtu_hit(paddr, `MTU_OFF_DELAY)) begin
                s_d.delay = pwdata;
            end else if (mtu_hit(paddr, `MTU_OFF_TIMEOUT)) begin
                s_d.tout = pwdata;
            end else if (mtu_hit(paddr, `MTU_OFF_GAP)) begin
                s_d.gap = pwdata[15:0];
            end else if (mtu_hit(paddr, `MTU_OFF_IRQ_STAT)) begin
                s_d.irq_st = s_q.irq_st & ~pwdata[2:0];
            end else if (mtu_hit(paddr, `MTU_OFF_IRQ_MASK)) begin
                s_d.irq_mk = pwdata[2:0];
            end else if (!mtu_hit(paddr, `MTU_OFF_STATUS) &&
                         !mtu_hit(paddr, `MTU_OFF_STAMP)) begin
                s_d.err = 1'b1;                               // unmapped address
            end
        end
        s_d.rdata = 32'h00000000;
        if (rd) begin
            case (paddr)
                `MTU_OFF_CTRL:     s_d.rdata = {22'h000000, s_q.mark_sel, 2'h0,
                                                s_q.arm, s_q.remote, s_q.slope, s_q.src};
                `MTU_OFF_THRESH:   s_d.rdata = {16'h0000, s_q.thresh};
                `MTU_OFF_DELAY:    s_d.rdata = s_q.delay;
                `MTU_OFF_TIMEOUT:  s_d.rdata = s_q.tout;
                `MTU_OFF_GAP:      s_d.rdata = {16'h0000, s_q.gap};
                `MTU_OFF_STATUS:   s_d.rdata = {26'h0000000, s_q.timed_out, s_q.arm, s_q.st};
                `MTU_OFF_IRQ_STAT: s_d.rdata = {29'h00000000, s_q.irq_st};
                `MTU_OFF_IRQ_MASK: s_d.rdata = {29'h00000000, s_q.irq_mk};
                `MTU_OFF_STAMP:    s_d.rdata = s_q.stamp;
                default:           s_d.err   = 1'b1;
            endcase
        end
        // new events set after the clear so the set wins
        s_d.irq_st = s_d.irq_st | ev;
        s_d.irq    = |(s_d.irq_st & s_d.irq_mk);
        // taken from the next state so the flop tracks the state with no lag
        s_d.busy   = (s_d.st != MTU_ST_IDLE);
    end
    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q        <= '0;
            s_q.st     <= MTU_ST_IDLE;
            s_q.thresh <= `MTU_RST_THRESH;
            s_q.tout   <= `MTU_RST_TIMEOUT;
            s_q.gap    <= `MTU_RST_GAP;
            s_q.delay  <= `MTU_RST_DELAY;
        end else begin
            s_q <= s_d;
        end
    end
    assign prdata       = s_q.rdata;
    assign pready       = s_q.rdy;
    assign pslverr      = s_q.err;
    assign meas_start   = s_q.start;
    assign meas_busy    = s_q.busy;
    assign trig_timeout = s_q.timed_out;
    assign irq          = s_q.irq;
endmodule

// ==== testbench/mtu_props.sv ====
// checker: port level properties of the measurement trigger unit
`timescale 1ns/1ps
module mtu_props #(
    parameter int MARK_N = 4
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [15:0]       power_level,
    input wire logic              ext_trigger_in_first,
    input wire logic              ext_trigger_in_second,
    input wire logic [MARK_N-1:0] marker_in,
    input wire logic              downlink_frame,
    input wire logic              meas_start,
    input wire logic              meas_busy,
    input wire logic              trig_timeout,
    input wire logic              irq
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // one wait state: never early, never late
    a_ready_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not one cycle after access start");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    // even free run leaves two quiet cycles between starts
    a_start_spacing: assert property (meas_start |=> !meas_start [*2])
        else $error("starts closer than three cycles");
    a_start_busy: assert property (meas_start |-> meas_busy)
        else $error("start while idle");
    a_tout_from_wait: assert property ($rose(trig_timeout) |-> $past(meas_busy))
        else $error("timeout without waiting");
    // reset must silence start, ready, irq and timeout outputs, so this one is never disabled
    a_reset_quiet: assert property (disable iff (1'b0)
        !presetn |-> !meas_start && !pready && !irq && !trig_timeout)
        else $error("output active in reset");
endmodule

// ==== testbench/mtu_far.sv ====
// far side model: rf power level and the trigger pulse sources
`timescale 1ns/1ps
module mtu_far #(
    parameter int MARK_N = 4
) (
    input  wire logic        pclk,
    output logic [15:0]      level,
    output logic             ext_a,
    output logic             ext_b,
    output logic [MARK_N-1:0] mark,
    output logic             dl
);
    // ****************
    // stimulus tasks
    // ****************
    initial begin
        level = 16'h0;
        ext_a = 1'b0;
        ext_b = 1'b0;
        mark  = '0;
        dl    = 1'b0;
    end
    // pulse held four cycles so the pin synchronisers cannot miss it
    task automatic fire(input int src, input int idx);
        @(posedge pclk);
        case (src)
            2: ext_a <= 1'b1;
            3: ext_b <= 1'b1;
            4: mark[idx] <= 1'b1;
            default: dl <= 1'b1;
        endcase
        repeat (4) @(posedge pclk);
        ext_a <= 1'b0;
        ext_b <= 1'b0;
        mark  <= '0;
        dl    <= 1'b0;
    endtask
    // hold a power level for n cycles
    task automatic hold(input logic [15:0] v, input int n);
        @(posedge pclk);
        level <= v;
        repeat (n - 1) @(posedge pclk);
    endtask
endmodule

// ==== testbench/tb_top.sv ====
// testbench top: apb master, scenarios and verdict for the trigger unit
`timescale 1ns/1ps
`include "mtu_map.svh"
module tb_top;
    import mtu_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b1; // dropped at time zero so reset sees a real edge
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_v;
    logic        pready, pslverr, meas_start, meas_busy, trig_timeout, irq, err_v;
    logic [15:0] lvl;
    logic        ea, eb, dl;
    logic [3:0]  mk;
    int          errors = 0;
    int          num_checks = 0;
    int          starts = 0;
    always #5 pclk = ~pclk;
    // registered pulse, read before this edge updates it
    always @(posedge pclk) if (meas_start === 1'b1) starts++;
    mtu_top #(.MARK_N(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_level(lvl), .ext_trigger_in_first(ea),
        .ext_trigger_in_second(eb), .marker_in(mk), .downlink_frame(dl),
        .meas_start(meas_start), .meas_busy(meas_busy), .trig_timeout(trig_timeout), .irq(irq));
    mtu_far #(.MARK_N(4)) u_far (.pclk(pclk), .level(lvl), .ext_a(ea), .ext_b(eb),
        .mark(mk), .dl(dl));
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; a trailing idle edge keeps drivers from clashing
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd_v, exp);
    endtask
    // cycles between two consecutive starts
    task automatic spacing(input int exp);
        int s, n;
        s = starts; n = 0;
        while (starts == s && n < 50) begin @(negedge pclk); n++; end
        s = starts; n = 0;
        while (starts == s && n < 50) begin @(negedge pclk); n++; end
        chk("start spacing", n, exp);
        @(posedge pclk);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_regs;
        rd_chk("thresh", `MTU_OFF_THRESH, 32'h00008000);
        rd_chk("gap", `MTU_OFF_GAP, 32'h00000064);
        rd_chk("timeout", `MTU_OFF_TIMEOUT, 32'h05f5e100);
        rd_chk("delay", `MTU_OFF_DELAY, 32'h0);
        rd_chk("status", `MTU_OFF_STATUS, 32'h00000001);
        rd_chk("unmapped", 12'h040, 32'h0);
        chk("unmapped err", err_v, 32'h1);
        $display("test regs done");
    endtask
    task automatic t_free;
        apb(1'b1, `MTU_OFF_THRESH, 32'hffff);
        apb(1'b1, `MTU_OFF_CTRL, 32'h28); // qualifiers set but free run
        spacing(3);
        apb(1'b1, `MTU_OFF_DELAY, 32'h2);
        spacing(5);
        apb(1'b1, `MTU_OFF_CTRL, 32'h0);
        apb(1'b1, `MTU_OFF_DELAY, 32'h0);
        $display("test free run done");
    endtask
    // ext a, ext b, marker and downlink sources: a foreign pulse is refused, its own pulse starts once
    task automatic t_src;
        int ctl[4] = '{32'h22, 32'h23, 32'h224, 32'h25};
        int ok[4] = '{2, 3, 4, 5};
        int bad[4] = '{3, 2, 4, 2};
        int s;
        logic [31:0] st0;
        time t0, t1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `MTU_OFF_CTRL, ctl[i]);
            s = starts;
            u_far.fire(bad[i], 1);
            repeat (12) @(posedge pclk);
            chk("foreign source", starts, s);
            t1 = $time;
            u_far.fire(ok[i], 2);
            repeat (12) @(posedge pclk);
            chk("own source", starts, s + 1);
            // same pin pipeline for every source, so stamps step like the pulses
            apb(1'b0, `MTU_OFF_STAMP, 32'h0);
            if (i > 0) chk("stamp step", rd_v - st0, 32'((t1 - t0) / 10));
            st0 = rd_v;
            t0 = t1;
        end
        apb(1'b1, `MTU_OFF_CTRL, 32'h0);
        rd_chk("irq status", `MTU_OFF_IRQ_STAT, 32'h3);
        apb(1'b1, `MTU_OFF_IRQ_MASK, 32'h2);
        repeat (2) @(negedge pclk);
        chk("irq enabled", irq, 32'h1);
        @(posedge pclk);
        apb(1'b1, `MTU_OFF_IRQ_MASK, 32'h0);
        repeat (2) @(negedge pclk);
        chk("irq masked", irq, 32'h0);
        @(posedge pclk);
        apb(1'b1, `MTU_OFF_IRQ_STAT, 32'h3);
        rd_chk("irq cleared", `MTU_OFF_IRQ_STAT, 32'h0);
        $display("test sources done");
    endtask
    task automatic t_power;
        int s;
        apb(1'b1, `MTU_OFF_THRESH, 32'h1000);
        apb(1'b1, `MTU_OFF_GAP, 32'h4);
        apb(1'b1, `MTU_OFF_CTRL, 32'h21);
        s = starts;
        u_far.hold(16'h0, 8);
        u_far.hold(16'h0800, 4);
        chk("below threshold", starts, s);
        u_far.hold(16'h2000, 3);
        repeat (6) @(posedge pclk);
        chk("rising crossing", starts, s + 1);
        u_far.hold(16'h0, 2);
        u_far.hold(16'h2000, 3);
        repeat (6) @(posedge pclk);
        chk("short gap", starts, s + 1);
        // falling slope: first drop has no gap behind it, rise is ignored
        apb(1'b1, `MTU_OFF_CTRL, 32'h29);
        u_far.hold(16'h0, 8);
        u_far.hold(16'h2000, 3);
        repeat (6) @(posedge pclk);
        chk("rise on falling slope", starts, s + 1);
        u_far.hold(16'h0, 3);
        repeat (6) @(posedge pclk);
        chk("falling crossing", starts, s + 2);
        apb(1'b1, `MTU_OFF_CTRL, 32'h0);
        apb(1'b1, `MTU_OFF_IRQ_STAT, 32'h7);
        $display("test power done");
    endtask
    task automatic t_tout;
        apb(1'b1, `MTU_OFF_TIMEOUT, 32'd20);
        apb(1'b1, `MTU_OFF_CTRL, 32'h32); // remote, external source
        repeat (40) @(posedge pclk);
        chk("timeout flag", trig_timeout, 32'h1);
        chk("remote stop", meas_busy, 32'h0);
        rd_chk("irq timeout", `MTU_OFF_IRQ_STAT, 32'h4);
        apb(1'b1, `MTU_OFF_CTRL, 32'h22);
        repeat (10) @(posedge pclk);
        u_far.fire(2, 0);
        repeat (8) @(posedge pclk);
        chk("timer restarted", trig_timeout, 32'h0);
        repeat (40) @(posedge pclk);
        chk("local keeps waiting", meas_busy, 32'h1);
        apb(1'b1, `MTU_OFF_CTRL, 32'h0);
        $display("test timeout done");
    endtask
    // ****************
    // main sequence and watchdog
    // ****************
    initial begin
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_free();
        t_src();
        t_power();
        t_tout();
        wrap_up();
    end
    // whole run needs well under two thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        $display("unexpected watchdog: expected end seen hang");
        wrap_up();
    end
endmodule
bind mtu_top mtu_props #(.MARK_N(MARK_N)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_level(power_level),
    .ext_trigger_in_first(ext_trigger_in_first), .ext_trigger_in_second(ext_trigger_in_second),
    .marker_in(marker_in), .downlink_frame(downlink_frame), .meas_start(meas_start),
    .meas_busy(meas_busy), .trig_timeout(trig_timeout), .irq(irq));
